//--- rtl/ptp_defines.svh
// Constants of the parallel token port: timing counts, field positions and codes
`ifndef PTP_DEFINES_SVH
`define PTP_DEFINES_SVH
// Clock rate in kHz and the shortest fast-transfer timeout in ms at this rate
`define PTP_CLK_KHZ 10000
`define PTP_FAST_TMO_MS 840
// Cycles of the timeout: ms * kHz, rounded up as a shortest time
`define PTP_FAST_TMO_CYC (`PTP_FAST_TMO_MS * `PTP_CLK_KHZ)
// Cycles that a consumed byte keeps the port busy
`define PTP_BUSY_CYC 4
// Reset pulse the device drives out after losing synchronisation
`define PTP_SELF_RST_CYC 8
// Handshake position in a status read
`define PTP_HS_BIT 0
`define PTP_NULL_BYTE 8'h00
`endif

//--- rtl/ptp_pkg.sv
// Types of the parallel token port
package ptp_pkg;
	// One host byte operation as seen on the port pins
	typedef struct packed {
		logic sel_n;
		logic rd_wr_n;
		logic register_select;
	} ptp_ctl_s;
	// Protocol phase of the device
	typedef enum logic [2:0] {
		PTP_HOST_LEN,
		PTP_HOST_DATA,
		PTP_HOST_TOKEN,
		PTP_DEV_LEN,
		PTP_DEV_DATA
	} ptp_state_e;
endpackage : ptp_pkg

//--- rtl/ptp_device_port.sv
// Device end of the byte-wide parallel token host port
// Behaviour
// - Reset line is two-way; host usually listens and captures its falling edges.
// - Status read: select low, read, register_select high; lowest data bit low means busy.
// - Data register is eight bits, used in both directions.
// - Data write: select low, write, register_select low, host drives eight lines.
// - Data read: select low, read, register_select low, device drives eight lines.
// - After reset host owns token: length, data bytes, null token byte.
// - After host sequence, device owns token; sends packet or returns token.
// - Late byte in fast window makes device reset itself.
// - Fast window after length byte read until packet fully read.
// - Fast window after zero length write until token byte written.
// - Host packet write: fast window from first data byte to token byte.
// - Interrupt whenever device has data for the host.
// - Interrupt when device owns token and will return null token.
// - Interrupt after accepting a non-zero length byte from the host.
// - Handshake reads busy right after each host write until consumed.
`timescale 1ns/10ps
`include "ptp_defines.svh"
module ptp_device_port #(
	parameter int unsigned FAST_TMO_CYC = `PTP_FAST_TMO_CYC // Long count, shortened in simulation
) (
	input wire logic i_ref_clk, // 10 MHz clock
	input wire logic i_resetn, // Asynchronous reset, active low
	input wire ptp_pkg::ptp_ctl_s i_ctl, // Host select, direction, register_select
	input wire logic [7:0] i_data, // Data lines from host
	output logic [7:0] o_data, // Data lines to host
	output logic o_data_oe, // High while device drives the data lines
	input wire logic i_rst_line_n, // Reset line as seen on the pin
	output logic o_rst_line_n, // Reset line value driven by device
	output logic o_rst_line_oe, // High while device drives the reset line
	output logic o_irq_n, // Interrupt to host, active low
	input wire logic i_tx_valid, // User has a packet byte for the host
	input wire logic [7:0] i_tx_data, // User byte: length first, then data
	output logic o_tx_ready, // Byte taken from user
	output logic o_rx_valid, // Pulse: host byte delivered to user
	output logic [7:0] o_rx_data, // Byte written by host
	output logic o_fast_mode // Fast-transfer window open
);
	import ptp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	ptp_state_e state_reg, state_next;
	logic [7:0] count_reg, count_next; // Bytes left in packet
	logic [7:0] out_reg, out_next; // Byte offered to the host
	logic out_full_reg, out_full_next; // Offered byte not yet read
	logic [2:0] busy_reg, busy_next; // Consume time after a host write
	logic fast_reg, fast_next;
	logic [31:0] tmo_reg, tmo_next;
	logic [3:0] srst_reg, srst_next; // Self reset pulse length
	logic sel_reg, sel_next; // Select edge detector
	logic [7:0] rx_reg, rx_next;
	logic rx_v_reg, rx_v_next;
	logic host_reset;
	logic tmo_hit; // Fast window ran out

	// Device owns the token in these phases
	function automatic logic dev_phase(input ptp_state_e s);
		return (s == PTP_DEV_LEN) || (s == PTP_DEV_DATA);
	endfunction : dev_phase
	logic op_start, wr_data, rd_data, rd_stat, ready;

	// Host reset and device self reset both return the protocol to the start
	assign host_reset = !i_rst_line_n && !o_rst_line_oe;
	assign op_start = !i_ctl.sel_n && !sel_reg;
	assign wr_data = op_start && !i_ctl.rd_wr_n && !i_ctl.register_select;
	assign rd_data = op_start && i_ctl.rd_wr_n && !i_ctl.register_select;
	assign rd_stat = !i_ctl.sel_n && i_ctl.rd_wr_n && i_ctl.register_select;
	// Ready when no write is still being consumed and, in device phases, a byte waits
	assign ready = (busy_reg == 3'h0) && (dev_phase(state_reg) ? out_full_reg : 1'b1);
	// Fast window overrun, shared by the restart and the reset pulse so both agree
	assign tmo_hit = fast_reg && (tmo_reg >= FAST_TMO_CYC - 1);

	// Pins: device drives data only during a read; handshake on the lowest data bit
	always_comb begin
		o_data_oe = !i_ctl.sel_n && i_ctl.rd_wr_n;
		o_data = out_reg;
		if (rd_stat) begin
			o_data = 8'h00;
			o_data[`PTP_HS_BIT] = ready;
		end
	end
	assign o_rst_line_oe = (srst_reg != 4'h0);
	assign o_rst_line_n = 1'b0;
	// Interrupt while a device byte waits (packet data or null token), and after a host
	// length byte until its first data byte; fast_reg is still low in exactly that span
	assign o_irq_n = !((out_full_reg && dev_phase(state_reg)) ||
		(state_reg == PTP_HOST_DATA && !fast_reg));
	assign o_tx_ready = dev_phase(state_reg) && !out_full_reg && i_tx_valid;
	assign o_fast_mode = fast_reg;
	assign o_rx_valid = rx_v_reg;
	assign o_rx_data = rx_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Protocol sequencer: host owns the token first, device answers after
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		out_next = out_reg;
		out_full_next = out_full_reg;
		busy_next = (busy_reg != 3'h0) ? busy_reg - 3'h1 : busy_reg;
		fast_next = fast_reg;
		tmo_next = fast_reg ? tmo_reg + 32'h1 : 32'h0;
		srst_next = (srst_reg != 4'h0) ? srst_reg - 4'h1 : srst_reg;
		sel_next = !i_ctl.sel_n;
		rx_next = rx_reg;
		rx_v_next = 1'b0;
		if (wr_data) begin
			busy_next = 3'(`PTP_BUSY_CYC);
			rx_next = i_data;
			rx_v_next = 1'b1;
			tmo_next = 32'h0;
			unique case (state_reg)
				PTP_HOST_LEN: begin
					count_next = i_data;
					if (i_data == `PTP_NULL_BYTE) begin
						state_next = PTP_HOST_TOKEN;
						fast_next = 1'b1;
					end else begin
						state_next = PTP_HOST_DATA;
						fast_next = 1'b0;
						out_full_next = 1'b0;
					end
				end
				PTP_HOST_DATA: begin
					fast_next = 1'b1;
					count_next = count_reg - 8'h1;
					if (count_reg == 8'h1) begin
						state_next = PTP_HOST_TOKEN;
					end
				end
				PTP_HOST_TOKEN: begin
					state_next = PTP_DEV_LEN;
					fast_next = 1'b0;
				end
				default: begin
				end
			endcase
		end else if (rd_data && out_full_reg) begin
			out_full_next = 1'b0;
			tmo_next = 32'h0;
			if (state_reg == PTP_DEV_LEN) begin
				count_next = out_reg;
				fast_next = (out_reg != 8'h00);
				state_next = (out_reg == 8'h00) ? PTP_HOST_LEN : PTP_DEV_DATA;
			end else begin
				count_next = count_reg - 8'h1;
				if (count_reg == 8'h1) begin
					state_next = PTP_HOST_LEN;
					fast_next = 1'b0;
				end
			end
		end else if (o_tx_ready) begin
			out_next = i_tx_data;
			out_full_next = 1'b1;
		end
		// Timeout in the fast window: pulse the reset line and restart
		if (tmo_hit) begin
			srst_next = 4'(`PTP_SELF_RST_CYC);
		end
		if (host_reset || tmo_hit) begin
			state_next = PTP_HOST_LEN;
			fast_next = 1'b0;
			out_full_next = 1'b0;
			busy_next = 3'h0;
			tmo_next = 32'h0;
		end
	end

	// State registers
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= PTP_HOST_LEN;
			count_reg <= 8'h00;
			out_reg <= 8'h00;
			out_full_reg <= 1'b0;
			busy_reg <= 3'h0;
			fast_reg <= 1'b0;
			tmo_reg <= 32'h0;
			srst_reg <= 4'h0;
			sel_reg <= 1'b0;
			rx_reg <= 8'h00;
			rx_v_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			out_reg <= out_next;
			out_full_reg <= out_full_next;
			busy_reg <= busy_next;
			fast_reg <= fast_next;
			tmo_reg <= tmo_next;
			srst_reg <= srst_next;
			sel_reg <= sel_next;
			rx_reg <= rx_next;
			rx_v_reg <= rx_v_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	busy_after_write_a: assert property (wr_data && !host_reset && !tmo_hit |=> (busy_reg == 3'(`PTP_BUSY_CYC)))
		else $error("not busy after write");
	null_len_fast_a: assert property (wr_data && state_reg == PTP_HOST_LEN && i_data == 8'h00 && !host_reset
		|=> fast_reg) else $error("no fast window after null length");
	len_no_fast_a: assert property (wr_data && state_reg == PTP_HOST_LEN && i_data != 8'h00 && !host_reset
		|=> !fast_reg) else $error("fast window on length byte");
	irq_on_byte_a: assert property (out_full_reg && state_reg == PTP_DEV_LEN |-> !o_irq_n) else $error("irq missing");
	len_irq_a: assert property (wr_data && state_reg == PTP_HOST_LEN && i_data != 8'h00 && !host_reset
		|=> !o_irq_n) else $error("no interrupt after length");
	token_pass_a: assert property (wr_data && state_reg == PTP_HOST_TOKEN && !host_reset && !tmo_hit
		|=> state_reg == PTP_DEV_LEN) else $error("token not taken");
	timeout_rst_a: assert property (tmo_hit |=> o_rst_line_oe [*8])
		else $error("no self reset on timeout");
	status_busy_a: assert property (rd_stat && busy_reg != 3'h0 |-> !o_data[0]) else $error("status not busy");
	read_consume_a: assert property (rd_data && out_full_reg |=> !out_full_reg) else $error("read byte kept");
	host_pkt_c: cover property (wr_data && state_reg == PTP_HOST_DATA);
	dev_pkt_c: cover property (rd_data && state_reg == PTP_DEV_DATA);
	timeout_c: cover property (o_rst_line_oe);
	len_irq_c: cover property (state_reg == PTP_HOST_DATA && !o_irq_n);
endmodule : ptp_device_port

//--- verification/ptp_host_model.sv
// Host processor model that works the pins of the parallel token port
`timescale 1ns/10ps
module ptp_host_model (
	input wire logic i_ref_clk, // 10 MHz clock
	input wire logic [7:0] i_dev_data, // Device data lines
	input wire logic i_dev_rst_n, // Device reset drive value
	input wire logic i_dev_rst_oe, // Device reset drive enable
	input wire logic i_dev_oe, // Device drives the data lines
	input wire logic i_dev_irq_n, // Device interrupt, active low
	input wire logic i_svc_n, // Service input, active low
	output ptp_pkg::ptp_ctl_s o_ctl, // Host control pins
	output logic [7:0] o_data, // Host data lines
	output logic o_line_n, // Resolved reset wire
	output logic o_seen_rst, // Captured reset edge
	output logic o_host_irq // Enabled interrupt seen by the host
);
	import ptp_pkg::*;
	logic drv = 1'b0;
	logic clr = 1'b0;
	logic [2:0] sync_reg = 3'b111;
	logic [1:0] irq_en = 2'b11; // Bit 0 device source, bit 1 service source
	logic [3:0] irq_sync_reg = 4'hf; // Two stages per source, service in the upper pair
	initial begin
		o_ctl = '{1'b1, 1'b1, 1'b1};
		o_data = 8'h00;
		o_seen_rst = 1'b0;
	end
	// Pulled-up wire, low while either side drives it
	assign o_line_n = !(drv || (i_dev_rst_oe && !i_dev_rst_n));
	// Synchronised before capture so a short glitch cannot half-set the flag
	always @(posedge i_ref_clk) begin
		sync_reg <= {sync_reg[1:0], o_line_n};
		irq_sync_reg <= {irq_sync_reg[2], i_svc_n, irq_sync_reg[0], i_dev_irq_n};
		if (clr) o_seen_rst <= 1'b0;
		else if (sync_reg[2:1] == 2'b10) o_seen_rst <= 1'b1;
	end
	// Each source masked on its own, only second stages are looked at
	assign o_host_irq = (irq_en[0] && !irq_sync_reg[1]) || (irq_en[1] && !irq_sync_reg[3]);
	// One byte operation; select stays low across both edges, data taken at the last
	task op(input logic rs, input logic rd, input logic [7:0] wd, output logic [7:0] q);
		@(posedge i_ref_clk) #1;
		o_ctl = '{1'b0, rd, rs};
		if (!rd) o_data = wd;
		repeat (2) @(posedge i_ref_clk);
		q = i_dev_oe ? i_dev_data : 8'hff; // undriven lines float to their pull-ups
		#1;
		o_ctl.sel_n = 1'b1;
		o_data = ~o_data; // Released lines do not keep the last value
	endtask : op
	// Poll the handshake, bounded
	task ready(output logic ok);
		logic [7:0] q;
		ok = 1'b0;
		for (int n = 0; n < 64 && !ok; n++) begin
			op(1'b1, 1'b1, 8'h00, q);
			ok = q[0];
		end
	endtask : ready
	task xfer(input logic rd, input logic [7:0] wd, output logic [7:0] q);
		logic ok;
		ready(ok);
		op(1'b0, rd, wd, q);
	endtask : xfer
	// Drive reset, release the pin, then forget the edge it caused
	task hreset;
		@(posedge i_ref_clk) #1 drv = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		#1 drv = 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#1 clr = 1'b1;
		@(posedge i_ref_clk) #1 clr = 1'b0;
	endtask : hreset
endmodule : ptp_host_model

//--- verification/parallel_token_host_port_tb.sv
// Self-checking bench of the device end of the parallel token port
`timescale 1ns/10ps
module parallel_token_host_port_tb;
	import ptp_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, txv = 1'b0, svc_n = 1'b1, ok;
	logic oe, hirq;
	logic [7:0] txd = 8'h00, hdata, odata, rxd, q;
	logic line_n, rst_n, rst_oe, irq_n, txr, rxv, fast, seen;
	ptp_ctl_s ctl;
	logic [7:0] rxq[$];
	logic [7:0] exp_rx[6] = '{8'h00, 8'h00, 8'h02, 8'ha5, 8'h3c, 8'h00};
	int num_errors = 0, checked = 0, cycles = 0;
	always #50 clk = ~clk;
	ptp_device_port #(.FAST_TMO_CYC(50)) i_ptp_device_port (.i_ref_clk(clk), .i_resetn(resetn), .i_ctl(ctl),
		.i_data(hdata), .o_data(odata), .o_data_oe(oe), .i_rst_line_n(line_n), .o_rst_line_n(rst_n),
		.o_rst_line_oe(rst_oe), .o_irq_n(irq_n), .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr),
		.o_rx_valid(rxv), .o_rx_data(rxd), .o_fast_mode(fast));
	ptp_host_model i_ptp_host_model (.i_ref_clk(clk), .i_dev_data(odata), .i_dev_rst_n(rst_n),
		.i_dev_rst_oe(rst_oe), .i_dev_oe(oe), .i_dev_irq_n(irq_n), .i_svc_n(svc_n), .o_ctl(ctl),
		.o_data(hdata), .o_line_n(line_n), .o_seen_rst(seen), .o_host_irq(hirq));
	// Bytes the host wrote, as handed to the user side
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (rxv === 1'b1) rxq.push_back(rxd);
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk
	// User byte to the host; held until taken, bounded wait
	task send_tx(input logic [7:0] b);
		@(posedge clk) #1;
		txv = 1'b1;
		txd = b;
		// Taken at the first edge at which ready stood high
		for (int n = 0; n < 2000; n++) begin
			@(posedge clk);
			if (txr === 1'b1) break;
		end
		#1 txv = 1'b0;
	endtask : send_tx
	task wrap_up;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		i_ptp_host_model.op(1'b1, 1'b1, 8'h00, q);
		chk("status", 8'h01, q);
		chk("irq idle", 8'h01, {7'h00, irq_n});
		// Null token handover: two zero bytes
		i_ptp_host_model.xfer(1'b0, 8'h00, q);
		i_ptp_host_model.op(1'b1, 1'b1, 8'h00, q);
		chk("busy after write", 8'h00, q);
		chk("fast after zero", 8'h01, {7'h00, fast});
		i_ptp_host_model.xfer(1'b0, 8'h00, q);
		chk("fast after token", 8'h00, {7'h00, fast});
		fork send_tx(8'h00); join_none
		i_ptp_host_model.ready(ok);
		chk("irq null token", 8'h00, {7'h00, irq_n});
		i_ptp_host_model.op(1'b0, 1'b1, 8'h00, q);
		chk("returned token", 8'h00, q);
		// Host packet of two data bytes
		i_ptp_host_model.xfer(1'b0, 8'h02, q);
		chk("fast after length", 8'h00, {7'h00, fast});
		chk("irq after length", 8'h00, {7'h00, irq_n});
		i_ptp_host_model.xfer(1'b0, 8'ha5, q);
		chk("fast after data", 8'h01, {7'h00, fast});
		i_ptp_host_model.xfer(1'b0, 8'h3c, q);
		i_ptp_host_model.xfer(1'b0, 8'h00, q);
		chk("fast end", 8'h00, {7'h00, fast});
		chk("rx count", 8'h06, 8'(rxq.size()));
		foreach (exp_rx[i]) chk("rx byte", exp_rx[i], rxq[i]);
		// Device packet of three data bytes
		fork begin
			send_tx(8'h03);
			for (int i = 1; i < 4; i++) send_tx(8'(i * 17));
		end join_none
		i_ptp_host_model.ready(ok);
		chk("irq data", 8'h00, {7'h00, irq_n});
		repeat (2) @(posedge clk);
		#1 chk("host irq", 8'h01, {7'h00, hirq});
		i_ptp_host_model.irq_en = 2'b10;
		svc_n = 1'b0;
		@(posedge clk) #1 chk("irq masked", 8'h00, {7'h00, hirq});
		@(posedge clk) #1 chk("service irq", 8'h01, {7'h00, hirq});
		svc_n = 1'b1;
		i_ptp_host_model.irq_en = 2'b11;
		i_ptp_host_model.op(1'b0, 1'b1, 8'h00, q);
		chk("rd length", 8'h03, q);
		chk("fast rd", 8'h01, {7'h00, fast});
		for (int i = 1; i < 4; i++) begin
			i_ptp_host_model.xfer(1'b1, 8'h00, q);
			chk("rd data", 8'(i * 17), q);
		end
		chk("fast rd end", 8'h00, {7'h00, fast});
		// Stall inside the fast window until the device resets itself
		i_ptp_host_model.xfer(1'b0, 8'h01, q);
		i_ptp_host_model.xfer(1'b0, 8'h77, q);
		for (int n = 0; n < 80 && rst_oe !== 1'b1; n++) @(posedge clk);
		chk("self reset", 8'h01, {7'h00, rst_oe});
		repeat (12) @(posedge clk);
		chk("edge seen", 8'h01, {7'h00, seen});
		i_ptp_host_model.hreset();
		i_ptp_host_model.ready(ok);
		chk("ready after reset", 8'h01, {7'h00, ok});
		chk("edge cleared", 8'h00, {7'h00, seen});
		wrap_up();
	end
endmodule : parallel_token_host_port_tb
